// >>> sbsc_defines.svh
// constants for the burst sram cycle control block
// Notes on behaviour
// RULE_01 - mode high: interleaved order, start xor beat
// RULE_02 - mode low: linear order, add one, wrap
// RULE_03 - sleep request asynchronous, data released, inputs ignored
// RULE_04 - two cycles to enter and leave sleep
// RULE_05 - memory contents kept through sleep
// RULE_06 - access pending at sleep entry abandoned
// RULE_07 - master deselects before raising sleep request
// RULE_08 - master idle two cycles after sleep ends
// RULE_09 - primary or expansion select inactive gives deselect
// RULE_10 - processor strobe start is always read
// RULE_11 - controller strobe start reads or writes
// RULE_12 - no write in processor strobe start cycle
// RULE_13 - advance low steps burst address
// RULE_14 - advance high holds burst address, repeats
// RULE_15 - write when global or byte write active
// RULE_16 - master raises output enable before write
// RULE_17 - output enable combined asynchronously, masked on write
// RULE_18 - read drives data when output enable low
// RULE_19 - burst counter loaded from two low address bits
// RULE_20 - upper address bits held through burst
`ifndef SBSC_DEFINES_SVH
`define SBSC_DEFINES_SVH
`define SBSC_ADDR_W 18
`define SBSC_DATA_W 36
`define SBSC_LANES 4
`define SBSC_DEPTH 262144
`define SBSC_CLK_NS 8
`define SBSC_SLEEP_ENTER_CYC 2
`define SBSC_SLEEP_EXIT_CYC 2
`define SBSC_SLEEP_CNT_W 2
`endif

// >>> sbsc_pkg.sv
// types for the burst sram cycle control block
package sbsc_pkg;
   typedef enum logic [1:0] {
      SBSC_IDLE,
      SBSC_READ,
      SBSC_WRITE
   } sbsc_cycle_t;
   typedef enum logic [1:0] {
      SBSC_AWAKE,
      SBSC_ENTERING,
      SBSC_ASLEEP,
      SBSC_WAKING
   } sbsc_sleep_t;
endpackage

// >>> sbsc_burst_addr.sv
// two-bit burst address generator
`timescale 1ns/100ps
`include "sbsc_defines.svh"
module sbsc_burst_addr (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic step_i,
   input wire logic interleave_i,
   input wire logic [1:0] start_i,
   output logic [1:0] addr_o
);
   logic [1:0] start;
   logic [1:0] beat;
   logic [1:0] next_beat;
   logic [1:0] base;
   logic [1:0] lin_addr;
   logic [1:0] ilv_addr;
   assign next_beat = load_i ? 2'h0 : (step_i ? beat + 2'h1 : beat);
   // address of the access at this edge: a start sees its own pins, a step the next beat
   assign base = load_i ? start_i : start;
   // RULE_01 interleaved xor sequence
   assign ilv_addr = base ^ next_beat;
   // RULE_02 linear wrapping sum
   assign lin_addr = base + next_beat;
   assign addr_o = interleave_i ? ilv_addr : lin_addr;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         start <= 2'h0;
         beat <= 2'h0;
      end else begin
         // RULE_19 counter loaded at start
         if (load_i) begin
            start <= start_i;
         end
         beat <= next_beat;
      end
   end
endmodule

// >>> sbsc_cycle_ctrl.sv
// burst sram cycle decode, burst addressing, sleep and data pin control
`timescale 1ns/100ps
`include "sbsc_defines.svh"
module sbsc_cycle_ctrl (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic sleep_request_i,
   input wire logic burst_mode_i,
   input wire logic chip_sel_primary_n_i,
   input wire logic chip_sel_expand_hi_i,
   input wire logic chip_sel_expand_lo_n_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic burst_advance_n_i,
   input wire logic global_write_n_i,
   input wire logic byte_write_enable_n_i,
   input wire logic [`SBSC_LANES-1:0] byte_lane_select_n_i,
   input wire logic output_enable_n_i,
   input wire logic [`SBSC_ADDR_W-1:0] addr_i,
   input wire logic [`SBSC_DATA_W-1:0] data_i,
   output logic [`SBSC_DATA_W-1:0] data_o,
   output logic data_oe_o,
   output logic sleeping_o
);
   localparam int LANE_W = `SBSC_DATA_W / `SBSC_LANES;
   logic [`SBSC_DATA_W-1:0] mem [0:`SBSC_DEPTH-1];
   logic [`SBSC_ADDR_W-3:0] addr_hi;
   logic [1:0] burst_lo;
   logic [`SBSC_ADDR_W-1:0] cur_addr;
   logic [`SBSC_ADDR_W-1:0] acc_addr;
   sbsc_pkg::sbsc_cycle_t cycle;
   sbsc_pkg::sbsc_cycle_t next_cycle;
   sbsc_pkg::sbsc_sleep_t sleep_st;
   sbsc_pkg::sbsc_sleep_t next_sleep_st;
   logic [`SBSC_SLEEP_CNT_W-1:0] sleep_cnt;
   logic [`SBSC_SLEEP_CNT_W-1:0] next_sleep_cnt;
   logic [`SBSC_LANES-1:0] lane_we;
   logic all_sel;
   logic desel;
   logic start_p;
   logic start_c;
   logic cont;
   logic is_write;
   logic active;
   logic in_burst;
   logic load;
   logic step;
   logic do_write;
   logic halted;

   // RULE_15 combined write indication
   function automatic logic write_ind(input logic gw_n, input logic bwe_n,
                                      input logic [`SBSC_LANES-1:0] bws_n);
      write_ind = !gw_n || (!bwe_n && !(&bws_n));
   endfunction

   assign is_write = write_ind(global_write_n_i, byte_write_enable_n_i,
                               byte_lane_select_n_i);
   assign all_sel = !chip_sel_primary_n_i && chip_sel_expand_hi_i &&
                    !chip_sel_expand_lo_n_i;
   // RULE_03 sleep request blocks every input
   assign active = (sleep_st == sbsc_pkg::SBSC_AWAKE) && !sleep_request_i;
   // RULE_09 deselect decode
   assign desel = active && ((chip_sel_primary_n_i && !controller_addr_strobe_n_i) ||
                  (!chip_sel_primary_n_i && !(chip_sel_expand_hi_i && !chip_sel_expand_lo_n_i) &&
                   (!processor_addr_strobe_n_i || !controller_addr_strobe_n_i)));
   // RULE_10 processor strobe start
   assign start_p = active && all_sel && !processor_addr_strobe_n_i;
   // RULE_11 controller strobe start
   assign start_c = active && all_sel && processor_addr_strobe_n_i &&
                    !controller_addr_strobe_n_i;
   assign cont = active && in_burst && controller_addr_strobe_n_i &&
                 (processor_addr_strobe_n_i || chip_sel_primary_n_i);
   assign load = start_p || start_c;
   // RULE_13 advance low steps
   // RULE_14 advance high holds address
   assign step = cont && !burst_advance_n_i;

   // RULE_12 no write in processor start cycle
   always_comb begin
      next_cycle = sbsc_pkg::SBSC_IDLE;
      if (start_p) begin
         next_cycle = sbsc_pkg::SBSC_READ;
      end else if (start_c || cont) begin
         next_cycle = is_write ? sbsc_pkg::SBSC_WRITE : sbsc_pkg::SBSC_READ;
      end
   end

   sbsc_burst_addr u_burst (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .load_i(load),
      .step_i(step),
      .interleave_i(burst_mode_i),
      .start_i(addr_i[1:0]),
      .addr_o(burst_lo)
   );

   // RULE_20 upper address bits held
   assign cur_addr = {addr_hi, burst_lo};
   // the start cycle addresses the external pins, later beats the counter
   assign acc_addr = load ? addr_i : cur_addr;
   assign do_write = (next_cycle == sbsc_pkg::SBSC_WRITE);

   genvar g;
   generate
      for (g = 0; g < `SBSC_LANES; g++) begin : g_lane
         assign lane_we[g] = do_write &&
            (!global_write_n_i || !byte_lane_select_n_i[g]);
      end
   endgenerate

   // sleep entry and exit sequencing
   always_comb begin
      next_sleep_st = sleep_st;
      next_sleep_cnt = sleep_cnt;
      case (sleep_st)
         sbsc_pkg::SBSC_AWAKE: begin
            if (sleep_request_i) begin
               next_sleep_st = sbsc_pkg::SBSC_ENTERING;
               next_sleep_cnt = `SBSC_SLEEP_CNT_W'(`SBSC_SLEEP_ENTER_CYC - 1);
            end
         end
         sbsc_pkg::SBSC_ENTERING: begin
            // RULE_04 two cycle entry
            if (sleep_cnt == `SBSC_SLEEP_CNT_W'(0)) begin
               next_sleep_st = sleep_request_i ? sbsc_pkg::SBSC_ASLEEP :
                               sbsc_pkg::SBSC_AWAKE;
            end else begin
               next_sleep_cnt = sleep_cnt - `SBSC_SLEEP_CNT_W'(1);
            end
         end
         sbsc_pkg::SBSC_ASLEEP: begin
            if (!sleep_request_i) begin
               next_sleep_st = sbsc_pkg::SBSC_WAKING;
               next_sleep_cnt = `SBSC_SLEEP_CNT_W'(`SBSC_SLEEP_EXIT_CYC - 1);
            end
         end
         sbsc_pkg::SBSC_WAKING: begin
            // RULE_04 two cycle recovery
            if (sleep_request_i) begin
               next_sleep_st = sbsc_pkg::SBSC_ASLEEP;
            end else if (sleep_cnt == `SBSC_SLEEP_CNT_W'(0)) begin
               next_sleep_st = sbsc_pkg::SBSC_AWAKE;
            end else begin
               next_sleep_cnt = sleep_cnt - `SBSC_SLEEP_CNT_W'(1);
            end
         end
         default: begin
            next_sleep_st = sbsc_pkg::SBSC_AWAKE;
         end
      endcase
   end

   assign halted = sleep_st != sbsc_pkg::SBSC_AWAKE;
   assign sleeping_o = halted;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sleep_st <= sbsc_pkg::SBSC_AWAKE;
         sleep_cnt <= '0;
         cycle <= sbsc_pkg::SBSC_IDLE;
         in_burst <= 1'b0;
         addr_hi <= '0;
      end else begin
         sleep_st <= next_sleep_st;
         sleep_cnt <= next_sleep_cnt;
         // RULE_06 pending access dropped on sleep
         cycle <= next_cycle;
         if (desel || !active) begin
            in_burst <= 1'b0;
         end else if (load) begin
            in_burst <= 1'b1;
         end
         if (load) begin
            addr_hi <= addr_i[`SBSC_ADDR_W-1:2];
         end
      end
   end

   // RULE_05 array untouched while asleep
   // one process for all lanes, since the array may have a single writer
   always_ff @(posedge ref_clk_i) begin
      for (int lane = 0; lane < `SBSC_LANES; lane++) begin
         if (lane_we[lane]) begin
            mem[acc_addr][lane*LANE_W +: LANE_W] <= data_i[lane*LANE_W +: LANE_W];
         end
      end
   end

   // flow-through read data
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         data_o <= '0;
      end else if (next_cycle == sbsc_pkg::SBSC_READ) begin
         data_o <= mem[acc_addr];
      end
   end

   // RULE_17 output enable asynchronous, masked on write
   // RULE_18 read drives pins when enable low
   assign data_oe_o = (cycle == sbsc_pkg::SBSC_READ) && !output_enable_n_i &&
                      !halted && !sleep_request_i;
endmodule

// >>> sbsc_cycle_checker.sv
// port assertions for the burst sram cycle control
`timescale 1ns/100ps
module sbsc_cycle_checker (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic sleep_request_i,
   input wire logic chip_sel_primary_n_i,
   input wire logic chip_sel_expand_hi_i,
   input wire logic chip_sel_expand_lo_n_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic output_enable_n_i,
   input wire logic data_oe_o,
   input wire logic sleeping_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire ps_go = !chip_sel_primary_n_i & chip_sel_expand_hi_i & !chip_sel_expand_lo_n_i
      & !processor_addr_strobe_n_i & !sleep_request_i & !sleeping_o;
   wire exp_off = !chip_sel_expand_hi_i | chip_sel_expand_lo_n_i;
   wire exp_desel = exp_off & !chip_sel_primary_n_i
      & (!processor_addr_strobe_n_i | !controller_addr_strobe_n_i);
   a_oe_sleep: assert property (sleep_request_i |-> !data_oe_o)
      else $error("data driven in sleep");
   a_oe_disabled: assert property (output_enable_n_i |-> !data_oe_o)
      else $error("data driven with enable high");
   a_sleep_entry: assert property ($rose(sleep_request_i) |-> ##[1:2] sleeping_o)
      else $error("sleep entry late");
   a_sleep_exit: assert property ($fell(sleep_request_i) |-> ##[1:3] !sleeping_o)
      else $error("sleep exit late");
   a_sleep_hold: assert property (sleep_request_i && sleeping_o |=> sleeping_o)
      else $error("sleep left while requested");
   a_exit_min: assert property ($fell(sleeping_o) |-> !$past(sleep_request_i, 2))
      else $error("sleep exit early");
   a_ps_read: assert property (ps_go ##1 !output_enable_n_i && !sleep_request_i |-> data_oe_o)
      else $error("start read not driven");
   a_deselect: assert property (chip_sel_primary_n_i && !controller_addr_strobe_n_i |=> !data_oe_o)
      else $error("deselect drives data");
   a_exp_desel: assert property (exp_desel |=> !data_oe_o)
      else $error("expansion deselect drives data");
   c_ps_read: cover property (ps_go ##1 data_oe_o);
   c_sleep: cover property ($rose(sleeping_o));
   c_wake: cover property ($fell(sleeping_o));
endmodule

// >>> sbsc_bus_master.sv
// bus master model driving the sram cycle pins
`timescale 1ns/100ps
module sbsc_bus_master (
   input wire logic ref_clk_i,
   output logic [6:0] bus_o,
   output logic [17:0] addr_o,
   output logic [35:0] data_o
);
   initial begin
      bus_o = 7'h6E;
      addr_o = 18'h0;
      data_o = 36'h0;
   end
   // c is {byte path, primary select, both strobes, advance, write}, low active except byte path, which is high for byte writes
   task automatic cyc(input logic [5:0] c, input logic [17:0] a, input logic [35:0] d);
      @(posedge ref_clk_i);
      bus_o <= {c[4:1], c[0] | c[5], c[0] | !c[5], !c[0] & c[3]};
      addr_o <= a;
      // released data lines toggle
      data_o <= c[0] ? ~data_o : d;
   endtask
endmodule

// >>> sbsc_cycle_ctrl_tb.sv
// testbench for the burst sram cycle control
`timescale 1ns/100ps
module sbsc_cycle_ctrl_tb;
   localparam logic [17:0] BASE = 18'h2A5C4;
   logic ref_clk_i, rst_i = 1'b1, sleep_request_i = 1'b0, burst_mode_i = 1'b0;
   logic nt = 1'b0, nd = 1'b0, data_oe_o, sleeping_o;
   logic [3:0] lanes_n = 4'h0;
   logic [1:0] x_off = 2'h0, x_next = 2'h0;
   logic [6:0] b;
   logic [17:0] addr;
   logic [35:0] wdata, data_o;
   logic [36:0] q[$];
   logic [36:0] e;
   logic [35:0] mem [logic [17:0]];
   int errors = 0, n_compared = 0, cyc_cnt = 0;
   sbsc_bus_master m (.ref_clk_i, .bus_o(b), .addr_o(addr), .data_o(wdata));
   sbsc_cycle_ctrl uut (.ref_clk_i, .rst_i, .sleep_request_i, .burst_mode_i,
      .chip_sel_primary_n_i(b[6]), .chip_sel_expand_hi_i(!x_off[1]),
      .chip_sel_expand_lo_n_i(x_off[0]),
      .processor_addr_strobe_n_i(b[5]), .controller_addr_strobe_n_i(b[4]),
      .burst_advance_n_i(b[3]), .global_write_n_i(b[2]), .byte_write_enable_n_i(b[1]),
      .byte_lane_select_n_i(lanes_n), .output_enable_n_i(b[0]), .addr_i(addr),
      .data_i(wdata), .data_o, .data_oe_o, .sleeping_o);
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp || $isunknown(got)) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic beat(input logic [5:0] c, input logic [1:0] lo);
      logic [17:0] a;
      logic [35:0] d;
      logic [35:0] lm;
      logic [3:0] ln;
      logic wr, ds;
      a = {BASE[17:2], lo};
      d = 36'({$urandom, $urandom});
      ln = 4'($urandom_range(14));
      lm = {{9{!ln[3]}}, {9{!ln[2]}}, {9{!ln[1]}}, {9{!ln[0]}}};
      ds = (c[4] & !c[2]) | ((|x_next) & !(c[3] & c[2]));
      wr = !c[0] & c[3] & !ds;
      m.cyc(c, (c[3] & c[2]) | ds ? ~a : a, d);
      lanes_n <= ln;
      x_off <= x_next;
      x_next = 2'h0;
      // enable raised ahead of a write releases the previous read
      if (!c[0] & c[3] && q.size() > 0) q[q.size() - 1][36] = 1'b0;
      q.push_back({!wr & !ds, wr | ds ? 36'h0 : mem[a]});
      if (wr) mem[a] = c[5] ? (mem[a] & ~lm) | (d & lm) : d;
      nt <= 1'b1;
   endtask
   always @(posedge ref_clk_i) begin
      nd <= nt;
      cyc_cnt++;
      if (cyc_cnt == 1000) begin
         errors++;
         complete_run();
      end
   end
   always @(negedge ref_clk_i) begin
      if (nd && q.size() > 0) begin
         e = q.pop_front();
         check(36'(data_oe_o), 36'(e[36]));
         if (e[36]) check(data_o, e[35:0]);
      end
   end
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      int i;
      logic v, w;
      logic [1:0] s, k;
      void'($urandom(9));
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      // linear write burst from 1, one beat by byte lanes
      beat(6'b001010, 1);
      beat(6'b011100, 2);
      beat(6'b011100, 3);
      beat(6'b001100, 0);
      beat(6'b111100, 1);
      beat(6'b011011, 0);
      for (i = 0; i < 8; i++) begin
         burst_mode_i <= i[0];
         s = 2'($urandom);
         k = 2'h0;
         beat(i[1] ? 6'b000110 : 6'b001011, s);
         repeat (3) begin
            v = 1'($urandom);
            w = 1'($urandom);
            k = k + 2'(!v);
            beat({4'b0111, v, w}, i[0] ? s ^ k : s + k);
         end
         x_next = i[2] ? 2'($urandom_range(3, 1)) : 2'h0;
         beat(i[2] ? 6'b001011 : 6'b011011, 0);
      end
      beat(6'b000111, 1);
      beat(6'b011011, 0);
      @(posedge ref_clk_i);
      sleep_request_i <= 1'b1;
      nt <= 1'b0;
      #1 check(36'(data_oe_o), 36'h0);
      @(posedge ref_clk_i);
      #1 check(36'(sleeping_o), 36'h1);
      m.cyc(6'b001010, BASE, 36'h0);
      m.cyc(6'b011011, BASE, 36'h0);
      sleep_request_i <= 1'b0;
      repeat (3) m.cyc(6'b011011, BASE, 36'h0);
      @(posedge ref_clk_i);
      #1 check(36'(sleeping_o), 36'h0);
      beat(6'b000111, 0);
      beat(6'b011011, 0);
      repeat (2) @(posedge ref_clk_i);
      complete_run();
   end
endmodule
bind sbsc_cycle_ctrl sbsc_cycle_checker chk (.ref_clk_i, .rst_i, .sleep_request_i,
   .chip_sel_primary_n_i, .chip_sel_expand_hi_i, .chip_sel_expand_lo_n_i,
   .processor_addr_strobe_n_i, .controller_addr_strobe_n_i, .output_enable_n_i,
   .data_oe_o, .sleeping_o);
